// >>> gac_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the gauge configuration bank.
// Assumes: 8-bit register index, 16-bit register words, 25 MHz clock.
// Notes: Definitions only.
`ifndef GAC_MAP_SVH
`define GAC_MAP_SVH
// ==========================================================
// Register offsets
`define GAC_OFS_HYP_LOAD 8'h04
`define GAC_OFS_DQ_ACC 8'h05
`define GAC_OFS_RESIDUAL 8'h0c
`define GAC_OFS_LEARN 8'h28
`define GAC_OFS_FILTER 8'h29
`define GAC_OFS_RELAX 8'h2a
`define GAC_OFS_MISC 8'h2b
`define GAC_OFS_DP_ACC 8'h46
`define GAC_OFS_CONVG 8'h49
`define GAC_OFS_RIPPLE 8'hbd
`define GAC_OFS_HYP_RESID 8'hdc
`define GAC_OFS_HYP_CTRL 8'he0
`define GAC_OFS_VG_OCV 8'hfb
`define GAC_OFS_VG_PCT 8'hff
// ==========================================================
// Reset values
`define GAC_RST_HYP_LOAD 16'h0000
`define GAC_RST_DQ_ACC 16'h0017
`define GAC_RST_DP_ACC 16'h0190
`define GAC_RST_LEARN 16'h4486
`define GAC_RST_FILTER 16'hcea4
`define GAC_RST_RELAX 16'h2039
`define GAC_RST_MISC 16'h3870
`define GAC_RST_CONVG 16'h2241
`define GAC_RST_RIPPLE 16'h0204
`define GAC_RST_HYP_CTRL 16'h0001
// ==========================================================
// Field positions
`define GAC_CURRENT_FILTER_CODE_MSB 3
`define GAC_CURRENT_FILTER_CODE_LSB 0
`define GAC_VOLTAGE_FILTER_CODE_MSB 6
`define GAC_VOLTAGE_FILTER_CODE_LSB 4
`define GAC_MIX_MSB 10
`define GAC_MIX_LSB 7
`define GAC_TEMP_MSB 13
`define GAC_TEMP_LSB 11
`define GAC_LOAD_MSB 15
`define GAC_LOAD_LSB 9
`define GAC_DV_MSB 8
`define GAC_DV_LSB 4
`define GAC_DT_MSB 3
`define GAC_DT_LSB 0
`define GAC_LS_MSB 6
`define GAC_LS_LSB 4
`define GAC_FUS_MSB 15
`define GAC_FUS_LSB 12
`define GAC_MR_MSB 9
`define GAC_MR_LSB 5
`define GAC_SA_MSB 1
`define GAC_SA_LSB 0
`define GAC_NR_MSB 2
`define GAC_NR_LSB 0
`define GAC_HYP_EN_BIT 0
// ==========================================================
// Codes, offsets and timing
`define GAC_LS_FINAL 3'h7
`define GAC_CURRENT_FILTER_CODE_BIAS 5'h07
`define GAC_VOLTAGE_FILTER_CODE_BIAS 5'h02
`define GAC_MIX_BIAS 5'h03
`define GAC_LOAD_SHIFT 5
`define GAC_DV_SHIFT 4
`define GAC_CLK_PERIOD_NS 40
`define GAC_BASE_TICK_NS 175781250
`define GAC_FIRST_UPDATE_MS 710
`endif

// >>> gac_pkg.sv
// Purpose: Types shared by the gauge configuration bank and its neighbours.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Widths follow the register fields.
package gac_pkg;
  // ========================================================
  // Results handed in by the gauge arithmetic.
  typedef struct packed {
    logic [15:0] residual;
    logic [15:0] hyp_residual;
    logic [15:0] hyp_tte;
    logic [15:0] hyp_pct;
    logic [15:0] blended_cap;
    logic [15:0] vg_ocv;
    logic [15:0] vg_pct;
    logic [15:0] dq_acc;
    logic [15:0] dp_acc;
  } gac_result_t;
  // Measurements and charge-state quantities from the analog side.
  typedef struct packed {
    logic [15:0] current_abs;
    logic [15:0] averaged_current_abs;
    logic [15:0] averaged_cell_voltage;
    logic [15:0] reported_charge_pct;
    logic [15:0] available_charge_pct;
    logic [15:0] blended_charge_pct;
  } gac_meas_t;
  // Settings handed to the gauge arithmetic.
  typedef struct packed {
    logic signed [4:0] current_tc_exp;
    logic signed [4:0] voltage_tc_exp;
    logic signed [4:0] blend_tc_exp;
    logic signed [4:0] temp_tc_exp;
    logic [2:0] ripple_filter_code;
    logic [5:0] full_update_pct;
    logic [4:0] servo_blend_rate;
    logic servo_blend_active;
    logic [2:0] learn_stage;
    logic [15:0] converge_cfg;
  } gac_setting_t;
endpackage : gac_pkg

// >>> gac_config_bank.sv
// Purpose: Configuration and intermediate-result register bank of a fuel-gauge algorithm.
// Assumes: Gauge arithmetic and measurement inputs are on clk; results arrive with result_valid.
// Notes: One-cycle read latency; host writes never stall.
// Notes on behaviour
// - Averaged-current time constant is 45 s times two to (code minus 7).
// - Averaged-voltage time constant is 45 s times two to (code minus 2).
// - Blending period is 45 s times two to (code minus 3).
// - Averaged-temperature time constant is 45 s times two to the code.
// - Relaxed after two consecutive quiet periods with low current and small voltage change.
// - Load threshold is 7 bits; instantaneous and averaged current both below it.
// - Voltage-delta threshold is 1.25 mV per step, default 3.75 mV.
// - Relaxation period is two to (code minus 8) times 45 s.
// - Learn stage starts at zero and advances to seven over seven learn_advance events.
// - Writing seven jumps to final stage; writing one through six is ignored.
// - Alert source select picks reported, available, blended or voltage-gauge charge.
// - Servo blend rate zero disables servo blending.
// - Servo blending acts only once the final learn stage is reached.
// - Full update slope gives 2 to 32 percent per fifteen minutes.
// - Converge-to-empty configuration resets to 0x2241.
// - Ripple filter time is 1.4 s times two to the ripple code.
// - Debug results get their first update within 710 ms of reset.
// - Charge change accumulator resets to 0x0017.
// - Charge-percent change accumulator resets to 0x0190.
// - Available capacity is blended capacity minus residual charge.
// - Hypothetical available capacity is blended capacity minus hypothetical residual.
// - Hypothetical results hold while the hypothetical-load enable is low.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "gac_map.svh"

module gac_config_bank
  import gac_pkg::*;
#(
  parameter int TICK_CYCLES = `GAC_BASE_TICK_NS / `GAC_CLK_PERIOD_NS,
  parameter int FIRST_UPDATE_CYCLES = `GAC_FIRST_UPDATE_MS * 1000000 / `GAC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire gac_result_t result_in,
  input wire logic result_valid,
  input wire gac_meas_t meas_in,
  input wire logic learn_advance,
  output gac_setting_t settings,
  output logic [15:0] hypothetical_load_current,
  output logic hypothetical_load_enable,
  output logic [15:0] available_capacity,
  output logic [15:0] hypothetical_available_capacity,
  output logic [15:0] hypothetical_time_to_empty,
  output logic [15:0] hypothetical_available_pct,
  output logic [15:0] alert_source_pct,
  output logic cell_relaxed,
  output logic data_ready
);

  // ========================================================
  // Register storage
  logic [15:0] learning_config;
  logic [15:0] averaging_filter_config;
  logic [15:0] relaxation_config;
  logic [15:0] miscellaneous_config;
  logic [15:0] converge_empty_config;
  logic [15:0] ripple_config;
  logic [15:0] hyp_ctrl;
  logic [15:0] charge_change_accum;
  logic [15:0] soc_change_accum;
  logic [15:0] residual_charge;
  logic [15:0] hypothetical_residual_charge;
  logic [15:0] voltage_gauge_open_circuit;
  logic [15:0] voltage_gauge_charge_pct;
  logic [15:0] blended_remaining_capacity;
  logic [2:0] learn_stage;
  logic [2:0] wr_stage;
  logic [31:0] boot_cnt;
  logic boot_done;
  logic take_result;
  logic [15:0] next_rdata;

  assign wr_stage = reg_wdata[`GAC_LS_MSB:`GAC_LS_LSB];
  // A result is taken when the arithmetic offers one, or once at the boot deadline.
  assign take_result = result_valid || (!boot_done && boot_cnt == 32'(FIRST_UPDATE_CYCLES - 1));

  // ========================================================
  // Plain configuration words; every bit, fixed ones too, is kept as written.
  always_ff @(posedge clk) begin
    if (rst) begin
      averaging_filter_config <= `GAC_RST_FILTER;
      relaxation_config <= `GAC_RST_RELAX;
      miscellaneous_config <= `GAC_RST_MISC;
      converge_empty_config <= `GAC_RST_CONVG;
      ripple_config <= `GAC_RST_RIPPLE;
      hyp_ctrl <= `GAC_RST_HYP_CTRL;
      hypothetical_load_current <= `GAC_RST_HYP_LOAD;
    end else if (reg_wr) begin
      case (reg_addr)
        `GAC_OFS_FILTER: averaging_filter_config <= reg_wdata;
        `GAC_OFS_RELAX: relaxation_config <= reg_wdata;
        `GAC_OFS_MISC: miscellaneous_config <= reg_wdata;
        `GAC_OFS_CONVG: converge_empty_config <= reg_wdata;
        `GAC_OFS_RIPPLE: ripple_config <= reg_wdata;
        `GAC_OFS_HYP_CTRL: hyp_ctrl <= reg_wdata;
        `GAC_OFS_HYP_LOAD: hypothetical_load_current <= reg_wdata;
        default: ;
      endcase
    end
  end
  assign hypothetical_load_enable = hyp_ctrl[`GAC_HYP_EN_BIT];

  // ========================================================
  // Learn stage: advances one step per event, a host write of seven jumps to the end.
  always_ff @(posedge clk) begin
    if (rst) begin
      learning_config <= `GAC_RST_LEARN;
      learn_stage <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == `GAC_OFS_LEARN) begin
        learning_config <= reg_wdata;
      end
      if (reg_wr && reg_addr == `GAC_OFS_LEARN && wr_stage == `GAC_LS_FINAL) begin
        learn_stage <= `GAC_LS_FINAL;
      end else if (learn_advance && learn_stage != `GAC_LS_FINAL) begin
        learn_stage <= learn_stage + 3'h1;
      end
    end
  end

  // ========================================================
  // Debug results; an arithmetic update wins over a host write in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_change_accum <= `GAC_RST_DQ_ACC;
      soc_change_accum <= `GAC_RST_DP_ACC;
      residual_charge <= 16'h0000;
      voltage_gauge_open_circuit <= 16'h0000;
      voltage_gauge_charge_pct <= 16'h0000;
      blended_remaining_capacity <= 16'h0000;
      available_capacity <= 16'h0000;
    end else if (take_result) begin
      charge_change_accum <= result_in.dq_acc;
      soc_change_accum <= result_in.dp_acc;
      residual_charge <= result_in.residual;
      voltage_gauge_open_circuit <= result_in.vg_ocv;
      voltage_gauge_charge_pct <= result_in.vg_pct;
      blended_remaining_capacity <= result_in.blended_cap;
      available_capacity <= result_in.blended_cap - result_in.residual;
    end else if (reg_wr && reg_addr == `GAC_OFS_DQ_ACC) begin
      charge_change_accum <= reg_wdata;
    end else if (reg_wr && reg_addr == `GAC_OFS_DP_ACC) begin
      soc_change_accum <= reg_wdata;
    end
  end

  // Hypothetical results freeze while the enable is low.
  always_ff @(posedge clk) begin
    if (rst) begin
      hypothetical_residual_charge <= 16'h0000;
      hypothetical_available_capacity <= 16'h0000;
      hypothetical_time_to_empty <= 16'h0000;
      hypothetical_available_pct <= 16'h0000;
    end else if (take_result && hypothetical_load_enable) begin
      hypothetical_residual_charge <= result_in.hyp_residual;
      hypothetical_available_capacity <= result_in.blended_cap - result_in.hyp_residual;
      hypothetical_time_to_empty <= result_in.hyp_tte;
      hypothetical_available_pct <= result_in.hyp_pct;
    end
  end

  // Boot deadline: forces the first capture so software never sees stale data.
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_cnt <= 32'h0;
      boot_done <= 1'b0;
      data_ready <= 1'b0;
    end else begin
      if (!boot_done) begin
        boot_cnt <= boot_cnt + 32'h1;
      end
      if (take_result) begin
        boot_done <= 1'b1;
        data_ready <= 1'b1;
      end
    end
  end

  // ========================================================
  // Relaxation detector: a base tick of 45 s / 256, a period of two to the code of ticks.
  logic [31:0] tick_cnt;
  logic [15:0] period_cnt;
  logic [15:0] period_len;
  logic [15:0] v_ref;
  logic [15:0] v_delta;
  logic [1:0] quiet_cnt;
  logic loaded;
  logic period_end;

  assign period_len = 16'h1 << relaxation_config[`GAC_DT_MSB:`GAC_DT_LSB];
  assign period_end = (tick_cnt == 32'(TICK_CYCLES - 1)) && (period_cnt >= period_len - 16'h1);
  // Both readings must sit below the threshold to count as unloaded.
  assign loaded = (meas_in.current_abs >= 16'(relaxation_config[`GAC_LOAD_MSB:`GAC_LOAD_LSB]) << `GAC_LOAD_SHIFT)
    || (meas_in.averaged_current_abs >= 16'(relaxation_config[`GAC_LOAD_MSB:`GAC_LOAD_LSB]) << `GAC_LOAD_SHIFT);
  assign v_delta = (meas_in.averaged_cell_voltage >= v_ref) ? meas_in.averaged_cell_voltage - v_ref
    : v_ref - meas_in.averaged_cell_voltage;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 32'h0;
      period_cnt <= 16'h0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0;
      period_cnt <= period_end ? 16'h0 : period_cnt + 16'h1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // A load restarts the count at once; the voltage is judged at each period end.
  always_ff @(posedge clk) begin
    if (rst) begin
      v_ref <= 16'h0;
      quiet_cnt <= 2'h0;
      cell_relaxed <= 1'b0;
    end else if (loaded) begin
      quiet_cnt <= 2'h0;
      cell_relaxed <= 1'b0;
      v_ref <= meas_in.averaged_cell_voltage;
    end else if (period_end) begin
      v_ref <= meas_in.averaged_cell_voltage;
      // Step is 1.25 mV against a voltage word of 1.25 mV / 16.
      if (v_delta < (16'(relaxation_config[`GAC_DV_MSB:`GAC_DV_LSB]) << `GAC_DV_SHIFT)) begin
        quiet_cnt <= (quiet_cnt == 2'h2) ? 2'h2 : quiet_cnt + 2'h1;
        cell_relaxed <= (quiet_cnt != 2'h0);
      end else begin
        quiet_cnt <= 2'h0;
        cell_relaxed <= 1'b0;
      end
    end
  end

  // ========================================================
  // Settings and alert source, registered so every output leaves a flip-flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      settings <= '0;
      alert_source_pct <= 16'h0;
    end else begin
      settings.current_tc_exp <= 5'(averaging_filter_config[`GAC_CURRENT_FILTER_CODE_MSB:`GAC_CURRENT_FILTER_CODE_LSB]) - `GAC_CURRENT_FILTER_CODE_BIAS;
      settings.voltage_tc_exp <= 5'(averaging_filter_config[`GAC_VOLTAGE_FILTER_CODE_MSB:`GAC_VOLTAGE_FILTER_CODE_LSB]) - `GAC_VOLTAGE_FILTER_CODE_BIAS;
      settings.blend_tc_exp <= 5'(averaging_filter_config[`GAC_MIX_MSB:`GAC_MIX_LSB]) - `GAC_MIX_BIAS;
      settings.temp_tc_exp <= 5'(averaging_filter_config[`GAC_TEMP_MSB:`GAC_TEMP_LSB]);
      settings.ripple_filter_code <= ripple_config[`GAC_NR_MSB:`GAC_NR_LSB];
      // Slope in percent per fifteen minutes: two times (code plus one).
      settings.full_update_pct <= {1'b0, miscellaneous_config[`GAC_FUS_MSB:`GAC_FUS_LSB], 1'b0} + 6'h2;
      settings.servo_blend_rate <= miscellaneous_config[`GAC_MR_MSB:`GAC_MR_LSB];
      // Servo only after the final stage, and never with a zero rate.
      settings.servo_blend_active <= (learn_stage == `GAC_LS_FINAL)
        && (miscellaneous_config[`GAC_MR_MSB:`GAC_MR_LSB] != 5'h00);
      settings.learn_stage <= learn_stage;
      settings.converge_cfg <= converge_empty_config;
      case (miscellaneous_config[`GAC_SA_MSB:`GAC_SA_LSB])
        2'h0: alert_source_pct <= meas_in.reported_charge_pct;
        2'h1: alert_source_pct <= meas_in.available_charge_pct;
        2'h2: alert_source_pct <= meas_in.blended_charge_pct;
        default: alert_source_pct <= voltage_gauge_charge_pct;
      endcase
    end
  end

  // ========================================================
  // Read port: data one cycle after the strobe, zero otherwise or when unmapped.
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `GAC_OFS_HYP_LOAD: next_rdata = hypothetical_load_current;
      `GAC_OFS_DQ_ACC: next_rdata = charge_change_accum;
      `GAC_OFS_RESIDUAL: next_rdata = residual_charge;
      `GAC_OFS_LEARN: next_rdata = {learning_config[15:7], learn_stage, learning_config[3:0]};
      `GAC_OFS_FILTER: next_rdata = averaging_filter_config;
      `GAC_OFS_RELAX: next_rdata = relaxation_config;
      `GAC_OFS_MISC: next_rdata = miscellaneous_config;
      `GAC_OFS_DP_ACC: next_rdata = soc_change_accum;
      `GAC_OFS_CONVG: next_rdata = converge_empty_config;
      `GAC_OFS_RIPPLE: next_rdata = ripple_config;
      `GAC_OFS_HYP_RESID: next_rdata = hypothetical_residual_charge;
      `GAC_OFS_HYP_CTRL: next_rdata = hyp_ctrl;
      `GAC_OFS_VG_OCV: next_rdata = voltage_gauge_open_circuit;
      `GAC_OFS_VG_PCT: next_rdata = voltage_gauge_charge_pct;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_stage_jump;
    reg_wr && reg_addr == `GAC_OFS_LEARN && wr_stage == `GAC_LS_FINAL |=> learn_stage == `GAC_LS_FINAL;
  endproperty
  a_stage_jump: assert property (p_stage_jump) else $error("stage write of seven not taken");

  property p_stage_ignore;
    reg_wr && reg_addr == `GAC_OFS_LEARN && wr_stage != `GAC_LS_FINAL && !learn_advance
      |=> learn_stage == $past(learn_stage);
  endproperty
  a_stage_ignore: assert property (p_stage_ignore) else $error("stage write not ignored");

  property p_stage_step;
    learn_advance && learn_stage != `GAC_LS_FINAL && !reg_wr |=> learn_stage == $past(learn_stage) + 3'h1;
  endproperty
  a_stage_step: assert property (p_stage_step) else $error("stage did not advance");

  property p_servo;
    ##1 settings.servo_blend_active |-> $past(learn_stage) == `GAC_LS_FINAL && settings.servo_blend_rate != 5'h00;
  endproperty
  a_servo: assert property (p_servo) else $error("servo active too early or at zero rate");

  property p_avail;
    take_result |=> available_capacity == $past(result_in.blended_cap) - $past(result_in.residual);
  endproperty
  a_avail: assert property (p_avail) else $error("available capacity wrong");

  property p_hyp_hold;
    !hypothetical_load_enable |=> $stable(hypothetical_residual_charge) && $stable(hypothetical_time_to_empty);
  endproperty
  a_hyp_hold: assert property (p_hyp_hold) else $error("hypothetical result moved while disabled");

  property p_boot;
    !boot_done |-> boot_cnt < 32'(FIRST_UPDATE_CYCLES);
  endproperty
  a_boot: assert property (p_boot) else $error("first update late");

  property p_relax_load;
    loaded |=> !cell_relaxed;
  endproperty
  a_relax_load: assert property (p_relax_load) else $error("relaxed under load");

  property p_read_lat;
    reg_rd && reg_addr == `GAC_OFS_CONVG && !reg_wr ##1 !$past(reg_wr) |-> reg_rdata == converge_empty_config;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data wrong");

  property p_alert_sel;
    miscellaneous_config[1:0] == 2'h3 |=> alert_source_pct == $past(voltage_gauge_charge_pct);
  endproperty
  a_alert_sel: assert property (p_alert_sel) else $error("alert source wrong");

  c_relaxed: cover property (!cell_relaxed ##1 cell_relaxed);
  c_final: cover property (learn_stage == 3'h6 ##1 learn_stage == `GAC_LS_FINAL);
  c_ready: cover property (!data_ready ##1 data_ready);

endmodule // gac_config_bank

// >>> gac_config_bank_tb.sv
// Purpose: Self-checking bench for the gauge configuration bank.
// Assumes: Short tick and boot counts; bus and result inputs change on the rising edge, most measurement changes 1 ns after it.
// Notes: Each scenario task drives the block and judges the result before it returns.
`timescale 1ns/1ps
`include "gac_map.svh"
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module testbench
  import gac_pkg::*;
;
  // ==========================================================
  // Clock, reset and stimulus signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  gac_result_t result_in = '0;
  logic result_valid = 1'b0;
  gac_meas_t meas_in = '0;
  logic learn_advance = 1'b0;
  gac_setting_t settings;
  logic [15:0] hyp_load, avail_cap, hyp_avail_cap, hyp_tte, hyp_pct, alert_pct;
  logic hyp_en, cell_relaxed, data_ready;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  gac_config_bank #(.TICK_CYCLES(4), .FIRST_UPDATE_CYCLES(50)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_in(result_in),
    .result_valid(result_valid), .meas_in(meas_in), .learn_advance(learn_advance), .settings(settings),
    .hypothetical_load_current(hyp_load), .hypothetical_load_enable(hyp_en), .available_capacity(avail_cap),
    .hypothetical_available_capacity(hyp_avail_cap), .hypothetical_time_to_empty(hyp_tte),
    .hypothetical_available_pct(hyp_pct), .alert_source_pct(alert_pct), .cell_relaxed(cell_relaxed),
    .data_ready(data_ready));

  // A hung run is cut short here; the ceiling is far above the expected length of a few hundred cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // Bus and helper tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge, so they are sampled just after that edge.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] ex);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHECK("read data", ex, reg_rdata)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic capture(input gac_result_t r);
    @(posedge clk);
    result_in <= r;
    result_valid <= 1'b1;
    @(posedge clk);
    result_valid <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    rd_chk(`GAC_OFS_CONVG, 16'h2241);
    `CHECK("not ready yet", 1'b0, data_ready)
    rd_chk(`GAC_OFS_DQ_ACC, 16'h0017);
    rd_chk(`GAC_OFS_DP_ACC, 16'h0190);
    rd_chk(`GAC_OFS_FILTER, 16'hcea4);
    rd_chk(`GAC_OFS_RELAX, 16'h2039);
    rd_chk(`GAC_OFS_LEARN, 16'h4486);
    rd_chk(`GAC_OFS_MISC, 16'h3870);
    rd_chk(`GAC_OFS_RIPPLE, 16'h0204);
    rd_chk(8'h33, 16'h0000);
    `CHECK("current exp", 5'sh1d, settings.current_tc_exp)
    `CHECK("voltage exp", 5'sh00, settings.voltage_tc_exp)
    `CHECK("blend exp", 5'sh0a, settings.blend_tc_exp)
    `CHECK("temp exp", 5'sh01, settings.temp_tc_exp)
    `CHECK("full update", 6'h08, settings.full_update_pct)
    `CHECK("learn stage", 3'h0, settings.learn_stage)
    `CHECK("converge out", 16'h2241, settings.converge_cfg)
    `CHECK("servo rate", 5'h03, settings.servo_blend_rate)
    `CHECK("hyp enable", 1'b1, hyp_en)
  endtask

  // Extreme codes of every filter field at once: current 15, voltage 0, blend 0, temperature 7.
  task automatic t_filter_codes();
    wr(`GAC_OFS_FILTER, 16'hf80f);
    settle(2);
    `CHECK("current exp", 5'sh08, settings.current_tc_exp)
    `CHECK("voltage exp", 5'sh1e, settings.voltage_tc_exp)
    `CHECK("blend exp", 5'sh1d, settings.blend_tc_exp)
    `CHECK("temp exp", 5'sh07, settings.temp_tc_exp)
    wr(`GAC_OFS_RIPPLE, 16'h0207);
    wr(`GAC_OFS_MISC, 16'hf870);
    settle(2);
    `CHECK("ripple code", 3'h7, settings.ripple_filter_code)
    `CHECK("full update", 6'h20, settings.full_update_pct)
  endtask

  task automatic t_learn_servo();
    wr(`GAC_OFS_LEARN, 16'h44b6);
    settle(2);
    `CHECK("stage after 3", 3'h0, settings.learn_stage)
    @(posedge clk);
    learn_advance <= 1'b1;
    @(posedge clk);
    learn_advance <= 1'b0;
    settle(1);
    `CHECK("stage advanced", 3'h1, settings.learn_stage)
    `CHECK("servo early", 1'b0, settings.servo_blend_active)
    wr(`GAC_OFS_LEARN, 16'h44f6);
    settle(2);
    `CHECK("stage final", 3'h7, settings.learn_stage)
    `CHECK("servo on", 1'b1, settings.servo_blend_active)
    wr(`GAC_OFS_MISC, 16'h3810);
    settle(2);
    `CHECK("servo off", 1'b0, settings.servo_blend_active)
  endtask

  task automatic t_results();
    gac_result_t r;
    `CHECK("boot update", 1'b1, data_ready)
    r = '0;
    r.blended_cap = 16'h03e8;
    r.residual = 16'h0064;
    r.hyp_residual = 16'h012c;
    r.hyp_tte = 16'h0055;
    r.hyp_pct = 16'h0066;
    r.vg_pct = 16'h0044;
    wr(`GAC_OFS_HYP_LOAD, 16'hff38);
    capture(r);
    settle(1);
    `CHECK("load out", 16'hff38, hyp_load)
    `CHECK("avail cap", 16'h0384, avail_cap)
    `CHECK("hyp avail", 16'h02bc, hyp_avail_cap)
    `CHECK("hyp tte", 16'h0055, hyp_tte)
    wr(`GAC_OFS_RESIDUAL, 16'hffff);
    rd_chk(`GAC_OFS_RESIDUAL, 16'h0064);
    rd_chk(`GAC_OFS_HYP_RESID, 16'h012c);
    wr(`GAC_OFS_HYP_CTRL, 16'h0000);
    r.residual = 16'h00c8;
    r.hyp_residual = 16'h0001;
    r.hyp_pct = 16'h0077;
    capture(r);
    settle(1);
    `CHECK("avail cap 2", 16'h0320, avail_cap)
    `CHECK("hyp avail held", 16'h02bc, hyp_avail_cap)
    `CHECK("hyp pct held", 16'h0066, hyp_pct)
    `CHECK("hyp enable off", 1'b0, hyp_en)
    wr(`GAC_OFS_DQ_ACC, 16'h0123);
    rd_chk(`GAC_OFS_DQ_ACC, 16'h0123);
  endtask

  // Every select code, each source with its own distinct value.
  task automatic t_alert_select();
    logic [15:0] exp_pct [4] = '{16'h0011, 16'h0022, 16'h0033, 16'h0044};
    for (int s = 0; s < 4; s++) begin
      wr(`GAC_OFS_MISC, 16'h3870 | 16'(s));
      settle(2);
      `CHECK("alert source", exp_pct[s], alert_pct)
    end
  endtask

  // Period of one tick keeps the two quiet periods short; dV stays at three steps.
  task automatic t_relax();
    wr(`GAC_OFS_RELAX, 16'h2030);
    settle(40);
    `CHECK("relaxed", 1'b1, cell_relaxed)
    meas_in.current_abs <= 16'h01ff;
    settle(20);
    `CHECK("below load", 1'b1, cell_relaxed)
    meas_in.current_abs <= 16'h0200;
    settle(10);
    `CHECK("loaded", 1'b0, cell_relaxed)
    meas_in.current_abs <= 16'h0000;
    settle(40);
    meas_in.averaged_cell_voltage <= 16'h8100;
    // The moved period end lands within four edges; relaxed cannot return before eight more.
    settle(6);
    `CHECK("voltage moved", 1'b0, cell_relaxed)
    // A load restarts the count; with four ticks per period the second quiet end is at least 16 edges away.
    meas_in.current_abs <= 16'h0200;
    wr(`GAC_OFS_RELAX, 16'h2032);
    meas_in.current_abs <= 16'h0000;
    settle(12);
    `CHECK("period four ticks", 1'b0, cell_relaxed)
    settle(28);
    `CHECK("relaxed again", 1'b1, cell_relaxed)
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    result_in.dq_acc = 16'h0017;
    result_in.dp_acc = 16'h0190;
    meas_in.averaged_cell_voltage = 16'h8000;
    meas_in.reported_charge_pct = 16'h0011;
    meas_in.available_charge_pct = 16'h0022;
    meas_in.blended_charge_pct = 16'h0033;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    settle(40);
    t_filter_codes();
    t_learn_servo();
    t_results();
    t_alert_select();
    t_relax();
    give_verdict();
  end
endmodule // testbench
